// ===== design/ccalu_map.vh
// constants for the compare and complement execution unit
`ifndef CCALU_MAP_VH
`define CCALU_MAP_VH
// opcodes
`define CCALU_OP_INV_R      8'h60
`define CCALU_OP_INV_IR     8'h61
`define CCALU_OP_CMP_RR_W   8'ha2
`define CCALU_OP_CMP_RIR_W  8'ha3
`define CCALU_OP_CMP_RR     8'ha4
`define CCALU_OP_CMP_RIR    8'ha5
`define CCALU_OP_CMP_IM     8'ha6
`define CCALU_OP_CBJE       8'hc2
// instruction lengths in bytes
`define CCALU_LEN_INV       2'd2
`define CCALU_LEN_CMP_W     2'd2
`define CCALU_LEN_CMP       2'd3
`define CCALU_LEN_CBJE      2'd3
// cycle counts
`define CCALU_CYC_INV       5'd4
`define CCALU_CYC_CMP_W     5'd4
`define CCALU_CYC_CMP       5'd6
`define CCALU_CYC_CBJE_T    5'd18
`define CCALU_CYC_CBJE_N    5'd16
// flag register address and bit positions
`define CCALU_FLAG_ADDR     8'hd5
`define CCALU_FLG_C         7
`define CCALU_FLG_Z         6
`define CCALU_FLG_S         5
`define CCALU_FLG_V         4
`define CCALU_FLG_D         3
`define CCALU_FLG_H         2
`define CCALU_FLAG_RST      8'h00
// apb register offsets
`define CCALU_REG_CTRL      8'h00
`define CCALU_REG_FLAGS     8'h04
`define CCALU_REG_STAT      8'h08
`define CCALU_REG_RESULT    8'h0c
`define CCALU_REG_PC        8'h10
`define CCALU_REG_PTR       8'h14
`endif

// ===== design/ccalu_core.v
// execution unit for complement, compare and compare-bump-jump-equal
//
// Function
// - invert writes the bitwise complement of the destination back to it
// - invert sets zero and sign from result, clears overflow, keeps c/d/h
// - invert opcodes 60 (register) and 61 (indirect), two bytes, 4 cycles
// - compare subtracts source from destination for flags and result register, no writeback
// - compare carry set on unsigned borrow, cleared otherwise
// - compare sets zero, sign, overflow from difference, keeps d and h
// - bump-jump-equal adds signed jump_offset to program_counter advanced past the instruction on zero difference
// - on nonzero difference program_counter advances past the instruction
// - source pointer register incremented by one in either case
// - bump-jump-equal leaves every flag unchanged
// - opcode c2, three bytes, register fields then jump_offset byte
// - bump-jump-equal takes 18 cycles taken, 16 cycles not taken
// - flags live in the flag register at address d5
`include "ccalu_map.vh"
`timescale 1ns/1ps
`default_nettype none
module ccalu_core #(
  parameter PC_W = 16
) (
  // clock and reset
  input  wire              clk_in,
  input  wire              rst_in,
  // apb slave
  input  wire              psel_in,
  input  wire              penable_in,
  input  wire              pwrite_in,
  input  wire [7:0]        paddr_in,
  input  wire [31:0]       pwdata_in,
  output wire              pready_out,
  output reg  [31:0]       prdata_out,
  output wire              pslverr_out,
  // status
  output wire              busy_out,
  output wire              done_out
);
  localparam ST_IDLE = 3'b001;
  localparam ST_RUN  = 3'b010;
  localparam ST_DONE = 3'b100;

  // ctrl: [7:0] opcode, [15:8] dst, [23:16] src, [31:24] jump_offset
  reg  [31:0]     ctrl_ff;
  reg  [7:0]      flags_ff;
  reg  [7:0]      result_ff;
  reg  [PC_W-1:0] program_counter_ff;
  reg  [7:0]      ptr_ff;
  reg  [2:0]      state_ff;
  reg  [4:0]      cnt_ff;
  reg  [4:0]      cycles_ff;
  reg             taken_ff;
  reg             illegal_ff;
  reg             wr_dst_ff;

  wire [7:0] opc    = ctrl_ff[7:0];
  wire [7:0] dst_v  = ctrl_ff[15:8];
  wire [7:0] src_v  = ctrl_ff[23:16];
  wire [7:0] offset = ctrl_ff[31:24];

  // shared arithmetic
  wire [8:0] diff   = {1'b0, dst_v} - {1'b0, src_v};
  wire [7:0] dres   = diff[7:0];
  wire       borrow = diff[8];
  wire       ovf    = (dst_v[7] ^ src_v[7]) & (dres[7] ^ dst_v[7]);
  wire [7:0] inv    = ~dst_v;

  wire is_inv  = (opc == `CCALU_OP_INV_R) || (opc == `CCALU_OP_INV_IR);
  wire is_cmpw = (opc == `CCALU_OP_CMP_RR_W) || (opc == `CCALU_OP_CMP_RIR_W);
  wire is_cmp3 = (opc == `CCALU_OP_CMP_RR) || (opc == `CCALU_OP_CMP_RIR)
                 || (opc == `CCALU_OP_CMP_IM);
  wire is_cbje = (opc == `CCALU_OP_CBJE);

  wire apb_wr = psel_in & penable_in & pwrite_in;
  wire apb_rd = psel_in & penable_in & ~pwrite_in;
  wire start  = apb_wr && (paddr_in == `CCALU_REG_CTRL) && (state_ff != ST_RUN);

  wire mapped = (paddr_in == `CCALU_REG_CTRL) || (paddr_in == `CCALU_REG_FLAGS)
                || (paddr_in == `CCALU_REG_STAT) || (paddr_in == `CCALU_REG_RESULT)
                || (paddr_in == `CCALU_REG_PC) || (paddr_in == `CCALU_REG_PTR);

  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~mapped;
  assign busy_out    = state_ff[1];
  assign done_out    = state_ff[2];

  // sign-extended displacement; range kept by software
  wire [PC_W-1:0] off_ext = {{(PC_W-8){offset[7]}}, offset};
  wire [1:0]      len     = (is_inv | is_cmpw) ? 2'd2 : 2'd3;
  wire [PC_W-1:0] pc_next = program_counter_ff + {{(PC_W-2){1'b0}}, len};

  // cycle count chosen at the decode edge from opcode and outcome
  reg [4:0] nxt_cycles;
  always @* begin
    if (is_cbje) begin
      nxt_cycles = (dres == 8'h00) ? `CCALU_CYC_CBJE_T : `CCALU_CYC_CBJE_N;
    end else if (is_inv) begin
      nxt_cycles = `CCALU_CYC_INV;
    end else if (opc == `CCALU_OP_CMP_RR_W) begin
      nxt_cycles = `CCALU_CYC_CMP_W;
    end else if (opc == `CCALU_OP_CMP_RIR_W) begin
      // indirect source costs the extra fetch although only two bytes
      nxt_cycles = `CCALU_CYC_CMP;
    end else begin
      nxt_cycles = `CCALU_CYC_CMP;
    end
  end

  // flag and result computation applied at end of execution
  reg [7:0] nxt_flags;
  always @* begin
    nxt_flags = flags_ff;
    if (is_inv) begin
      nxt_flags[`CCALU_FLG_Z] = (inv == 8'h00);
      nxt_flags[`CCALU_FLG_S] = inv[7];
      nxt_flags[`CCALU_FLG_V] = 1'b0;
    end else if (is_cmpw | is_cmp3) begin
      nxt_flags[`CCALU_FLG_C] = borrow;
      nxt_flags[`CCALU_FLG_Z] = (dres == 8'h00);
      nxt_flags[`CCALU_FLG_S] = dres[7];
      nxt_flags[`CCALU_FLG_V] = ovf;
    end
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_ff            <= 32'h00000000;
      flags_ff           <= `CCALU_FLAG_RST;
      result_ff          <= 8'h00;
      program_counter_ff <= {PC_W{1'b0}};
      ptr_ff             <= 8'h00;
      state_ff           <= ST_IDLE;
      cnt_ff             <= 5'h00;
      cycles_ff          <= 5'h00;
      taken_ff           <= 1'b0;
      illegal_ff         <= 1'b0;
      wr_dst_ff          <= 1'b0;
    end else begin
      case (state_ff)
        ST_RUN: begin
          if (cnt_ff == 5'h00) begin
            // decode edge: budget picked once ctrl holds the opcode
            cycles_ff  <= nxt_cycles;
            cnt_ff     <= 5'h01;
            illegal_ff <= ~(is_inv | is_cmpw | is_cmp3 | is_cbje);
            if (!(is_inv | is_cmpw | is_cmp3 | is_cbje)) begin
              state_ff <= ST_DONE;
            end
          end else if (cnt_ff == cycles_ff) begin
            state_ff  <= ST_DONE;
            if (!illegal_ff) begin
              flags_ff <= nxt_flags;
              if (is_inv) begin
                result_ff <= inv;
                wr_dst_ff <= 1'b1;
              end else begin
                result_ff <= dres;
                wr_dst_ff <= 1'b0;
              end
              if (is_cbje) begin
                ptr_ff <= src_v + 8'h01;
                if (dres == 8'h00) begin
                  program_counter_ff <= pc_next + off_ext;
                  taken_ff <= 1'b1;
                end else begin
                  program_counter_ff <= pc_next;
                  taken_ff <= 1'b0;
                end
              end else begin
                program_counter_ff <= pc_next;
                taken_ff <= 1'b0;
              end
            end
          end else begin
            cnt_ff <= cnt_ff + 5'h01;
          end
        end
        default: begin
          if (start) begin
            state_ff   <= ST_RUN;
            cnt_ff     <= 5'h00;
            cycles_ff  <= 5'h00;
            illegal_ff <= 1'b0;
          end
        end
      endcase
      if (start) begin
        ctrl_ff <= pwdata_in;
      end
      if (apb_wr && paddr_in == `CCALU_REG_FLAGS && state_ff != ST_RUN) begin
        flags_ff <= pwdata_in[7:0];
      end
      if (apb_wr && paddr_in == `CCALU_REG_PC && state_ff != ST_RUN) begin
        program_counter_ff <= pwdata_in[PC_W-1:0];
      end
    end
  end

  // apb read mux
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prdata_out <= 32'h00000000;
    end else if (psel_in & ~penable_in & ~pwrite_in) begin
      if (paddr_in == `CCALU_REG_CTRL) begin
        prdata_out <= ctrl_ff;
      end else if (paddr_in == `CCALU_REG_FLAGS) begin
        prdata_out <= {24'h000000, flags_ff};
      end else if (paddr_in == `CCALU_REG_STAT) begin
        prdata_out <= {22'h0, cycles_ff, wr_dst_ff, illegal_ff, taken_ff, state_ff[2], state_ff[1]};
      end else if (paddr_in == `CCALU_REG_RESULT) begin
        prdata_out <= {24'h000000, result_ff};
      end else if (paddr_in == `CCALU_REG_PC) begin
        prdata_out <= {{(32-PC_W){1'b0}}, program_counter_ff};
      end else if (paddr_in == `CCALU_REG_PTR) begin
        prdata_out <= {24'h000000, ptr_ff};
      end else begin
        prdata_out <= 32'h00000000;
      end
    end
  end

  wire unused_rd = apb_rd;
endmodule
`default_nettype wire

// ===== test/ccalu_core_asserts.sv
// port assertions for the execution unit
`timescale 1ns/1ps
`default_nettype none
module ccalu_core_asserts #(parameter PC_W = 16) (
  // clock, reset, apb
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic        pready_out,
  input wire logic [31:0] prdata_out,
  input wire logic        pslverr_out,
  // status
  input wire logic        busy_out,
  input wire logic        done_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire acc = psel_in && penable_in;
  // only a legal opcode is known to start
  sequence inv_start_s;
    acc && pwrite_in && paddr_in == 8'h00 && !busy_out && pwdata_in[7:0] == 8'h60;
  endsequence
  sequence run_s;
    busy_out[*4] ##[1:16] (done_out && !busy_out);
  endsequence
  start_busy_a: assert property (inv_start_s |=> run_s) else $error("invert run length");
  busy_len_a: assert property ($rose(busy_out) |-> run_s) else $error("busy length");
  end_done_a: assert property ($fell(busy_out) |-> done_out) else $error("no done");
  done_excl_a: assert property (done_out |-> !busy_out) else $error("done with busy");
  ready_up_a: assert property (pready_out) else $error("pready low");
  err_unmap_a: assert property (acc && paddr_in > 8'h14 |-> pslverr_out) else $error("no pslverr");
  err_map_a: assert property (acc && paddr_in <= 8'h14 && paddr_in[1:0] == 2'b00 |-> !pslverr_out)
    else $error("bad pslverr");
  err_idle_a: assert property (!acc |-> !pslverr_out) else $error("idle pslverr");
  rd_zero_a: assert property (psel_in && !penable_in && !pwrite_in && paddr_in > 8'h14 |=> prdata_out == 32'h0)
    else $error("unmapped data");
endmodule
bind ccalu_core ccalu_core_asserts #(.PC_W(PC_W)) u_chk (.clk_in, .rst_in, .psel_in, .penable_in,
  .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .prdata_out, .pslverr_out, .busy_out, .done_out);
`default_nettype wire

// ===== test/ccalu_apb_model.sv
// apb master standing in for the sequencer
`timescale 1ns/1ps
`default_nettype none
module ccalu_apb_model (
  // clock and answer
  input  wire logic        clk_in,
  input  wire logic        pready_in,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pslverr_in,
  // request
  output var  logic        psel_out,
  output var  logic        penable_out,
  output var  logic        pwrite_out,
  output var  logic [7:0]  paddr_out,
  output var  logic [31:0] pwdata_out
);
  int tmo = 0;
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 8'h00;
    pwdata_out = 32'h0;
  end
  // leading edge keeps back-to-back calls from double driving
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    @(posedge clk_in);
    psel_out <= 1'b1;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= w ? d : ~d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_in !== 1'b1 && n < 50);
    if (n >= 50) tmo++;
    q = prdata_in;
    e = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== test/ccalu_core_tb.sv
// self-checking bench for the execution unit
`include "ccalu_map.vh"
`timescale 1ns/1ps
`default_nettype none
module ccalu_core_tb;
  typedef struct packed {logic [7:0] op, d, s, off, fl, res; logic [15:0] pc; logic [4:0] cyc;} ccalu_row_t;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, busy, done, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  int          err_total = 0;
  int          checks_done = 0;
  // flags start as 8c, pc as 0100
  ccalu_row_t  rows [9] = '{
    {8'h60, 8'h07, 8'h00, 8'h00, 8'hac, 8'hf8, 16'h0102, 5'd4},
    {8'h61, 8'hff, 8'h00, 8'h00, 8'hcc, 8'h00, 16'h0102, 5'd4},
    {8'ha2, 8'h02, 8'h03, 8'h00, 8'hac, 8'hff, 16'h0102, 5'd4},
    {8'ha3, 8'h05, 8'h05, 8'h00, 8'h4c, 8'h00, 16'h0102, 5'd6},
    {8'ha4, 8'h80, 8'h01, 8'h00, 8'h1c, 8'h7f, 16'h0103, 5'd6},
    {8'ha5, 8'h7f, 8'hff, 8'h00, 8'hbc, 8'h80, 16'h0103, 5'd6},
    {8'ha6, 8'h10, 8'h10, 8'h00, 8'h4c, 8'h00, 16'h0103, 5'd6},
    {8'hc2, 8'h02, 8'h02, 8'h80, 8'h8c, 8'h00, 16'h0083, 5'd18},
    {8'hc2, 8'h02, 8'h03, 8'h7f, 8'h8c, 8'hff, 16'h0103, 5'd16}};
  always #4 clk_in = ~clk_in;
  ccalu_core dut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr),
    .busy_out(busy), .done_out(done));
  ccalu_apb_model bus (.clk_in(clk_in), .pready_in(pready), .prdata_in(prdata), .pslverr_in(pslverr),
    .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata));
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // hit writes flags while busy, which must be ignored
  task automatic run(input ccalu_row_t r, input logic hit);
    int n;
    bus.xfer(1'b1, `CCALU_REG_PC, 32'h100, q, e);
    bus.xfer(1'b1, `CCALU_REG_FLAGS, 32'h8c, q, e);
    bus.xfer(1'b1, `CCALU_REG_CTRL, {r.off, r.s, r.d, r.op}, q, e);
    if (hit) bus.xfer(1'b1, `CCALU_REG_FLAGS, 32'h0, q, e);
    n = 0;
    do begin
      bus.xfer(1'b0, `CCALU_REG_STAT, 32'h0, q, e);
      n++;
    end while (q[1] !== 1'b1 && n < 40);
    if (n >= 40 || bus.tmo > 0) begin
      err_total++;
      report_and_stop();
    end
    cmp({11'h0, q[9:5]}, {11'h0, r.cyc});
    cmp({15'h0, q[2]}, {15'h0, r.op == 8'hc2 && r.d == r.s});
    bus.xfer(1'b0, `CCALU_REG_FLAGS, 32'h0, q, e);
    cmp({8'h0, q[7:0]}, {8'h0, r.fl});
    bus.xfer(1'b0, `CCALU_REG_RESULT, 32'h0, q, e);
    cmp({8'h0, q[7:0]}, {8'h0, r.res});
    bus.xfer(1'b0, `CCALU_REG_PC, 32'h0, q, e);
    cmp(q[15:0], r.pc);
    if (r.op == 8'hc2) bus.xfer(1'b0, `CCALU_REG_PTR, 32'h0, q, e);
    if (r.op == 8'hc2) cmp({8'h0, q[7:0]}, {8'h0, r.s + 8'h01});
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    bus.xfer(1'b0, `CCALU_REG_FLAGS, 32'h0, q, e);
    cmp(q[15:0], 16'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      run(rows[i], 1'b0);
      $display("row %0d done", i);
    end
    run(rows[2], 1'b1);
    $display("busy write test done");
    bus.xfer(1'b0, 8'h18, 32'h0, q, e);
    cmp({e, q[14:0]}, 16'h8000);
    $display("unmapped test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
